// ---- rtl/cip_regs.vh ----
`ifndef CIP_REGS_VH
`define CIP_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CIP_MCR0 8'h00
`define CIP_MCR1 8'h04
`define CIP_BTR0 8'h08
`define CIP_BTR1 8'h0C
`define CIP_ACTL 8'h10
`define CIP_RFLG 8'h14
`define CIP_RIER 8'h18
`define CIP_TFLG 8'h1C
`define CIP_TIER 8'h20
`define CIP_ECNT 8'h24
`define CIP_MODE 8'h28
`define CIP_ACC_BASE 8'h40
`define CIP_MSK_BASE 8'h60
// ----------------------------------------
// control register 0 fields
// ----------------------------------------
`define CIP_SRST_BIT 0
`define CIP_SLRQ_BIT 1
`define CIP_SLAK_BIT 2
`define CIP_SIW_BIT 5
// ----------------------------------------
// receiver flag positions (enables alike)
// ----------------------------------------
`define CIP_RXF_BIT 0
`define CIP_OVR_BIT 1
`define CIP_BOFF_BIT 2
`define CIP_TPAS_BIT 3
`define CIP_RPAS_BIT 4
`define CIP_TWRN_BIT 5
`define CIP_RWRN_BIT 6
`define CIP_WUP_BIT 7
// ----------------------------------------
// limits, reset values, timing
// ----------------------------------------
`define CIP_WARN_LIM 9'h060
`define CIP_PASS_LIM 9'h07F
`define CIP_BOFF_LIM 9'h0FF
`define CIP_RESYNC_BITS 4'hB
`define CIP_TFLG_RST 3'h7
`define CIP_MCR0_RST 8'h01
`endif

// ---- rtl/cip_can_ctrl.v ----
// Function
// R1 - four vectors, eleven individually maskable sources
// R2 - transmit vector from enabled empty buffers
// R3 - receive-full set at end of frame
// R4 - wakeup flag needs sleep-ack and enable
// R5 - warning flags at error count 96
// R6 - passive above 127, bus-off above 255
// R7 - overrun when both receive buffers full
// R8 - request holds while enabled flag set
// R9 - write one clears flag, zero keeps
// R10 - clear ignored while cause persists
// R11 - software avoids read-modify-write flag clears
// R12 - error counters are read-only
// R13 - config registers writable only in soft reset
// R14 - mode from cpu state and bits
// R15 - sleep waits for transfers to finish
// R16 - sleep stops core, tx recessive
// R17 - no copy or abort during sleep
// R18 - leave sleep on activity or software
// R19 - sleep request clearable only after ack
// R20 - eleven recessive bits before rejoining bus; code rejoins at once after power-down in normal mode
// R21 - soft reset halts transfers at once
// R22 - power-down stops all, no register access
// R23 - vector request is or of enabled flags
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "cip_regs.vh"
module cip_can_ctrl (
  input wire CLK,              // 100 MHz clock
  input wire RSTN,             // async reset, low
  input wire [7:0] AWADDR,     // axi write address
  input wire AWVALID,          // axi
  output reg AWREADY,          // axi
  input wire [31:0] WDATA,     // axi
  input wire [3:0] WSTRB,      // axi
  input wire WVALID,           // axi
  output reg WREADY,           // axi
  output reg [1:0] BRESP,      // axi
  output reg BVALID,           // axi
  input wire BREADY,           // axi
  input wire [7:0] ARADDR,     // axi read address
  input wire ARVALID,          // axi
  output reg ARREADY,          // axi
  output reg [31:0] RDATA,     // axi
  output reg [1:0] RRESP,      // axi
  output reg RVALID,           // axi
  input wire RREADY,           // axi
  input wire CPU_STOP,         // cpu in stop mode
  input wire CPU_WAIT,         // cpu in wait mode
  input wire RX_ACCEPT,        // pulse: accepted frame at end of frame
  input wire [2:0] TX_DONE,    // pulse per buffer: sent or aborted
  input wire TX_BUSY,          // transmit pending or running
  input wire RX_BUSY,          // frame being received
  input wire BIT_TICK,         // pulse once per bit time
  input wire RX_PIN,           // bus level, 1 recessive
  input wire [7:0] RX_ERR_CNT, // receive error counter
  input wire [8:0] TX_ERR_CNT, // transmit error counter
  output reg IRQ_TX,           // transmit vector
  output reg IRQ_RX,           // receive vector
  output reg IRQ_WAKE,         // wakeup vector
  output reg IRQ_ERR,          // error vector
  output reg CORE_RUN,         // protocol engine clock enable
  output reg BUS_ONLINE,       // engine may join the bus
  output reg TX_RECESSIVE,     // force transmit pin recessive
  output reg COPY_STROBE,      // copy background into foreground
  output reg [7:0] BTR0_OUT,   // bus timing 0
  output reg [7:0] BTR1_OUT    // bus timing 1
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam S_SOFT = 2'd0;
  localparam S_SYNC = 2'd1;
  localparam S_NORM = 2'd2;
  localparam S_SLEEP = 2'd3;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] rec_cnt_reg;
  reg [7:0] mcr0_reg;
  reg [7:0] mcr1_reg;
  reg [7:0] actl_reg;
  reg [7:0] rflg_reg;
  reg [7:0] rier_reg;
  reg [2:0] tflg_reg;
  reg [2:0] tier_reg;
  reg bg_full_reg;
  reg [7:0] acc_mem [0:15];
  reg aw_got_reg;
  reg w_got_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire power_down = CPU_STOP | (CPU_WAIT & mcr0_reg[`CIP_SIW_BIT]); // [R14] [R22]
  wire soft_rst = mcr0_reg[`CIP_SRST_BIT];
  wire slp_req = mcr0_reg[`CIP_SLRQ_BIT];
  wire sleep_ack = (state_reg == S_SLEEP);
  wire running = ~power_down & ((state_reg == S_NORM) | (state_reg == S_SYNC));
  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire wr_go = aw_got_reg & w_got_reg & ~BVALID;
  wire wr_ok = wr_go & ~power_down & wstrb_reg[0]; // [R22]
  wire [7:0] wb = wdata_reg[7:0];
  wire wr_mcr0 = wr_ok & (awaddr_reg == `CIP_MCR0);
  wire wr_lock = wr_ok & soft_rst; // [R13]
  wire wr_rflg = wr_ok & (awaddr_reg == `CIP_RFLG);
  wire wr_tflg = wr_ok & (awaddr_reg == `CIP_TFLG);
  wire wr_acc = wr_lock & (awaddr_reg[7:6] == 2'b01) & (awaddr_reg[1:0] == 2'b00);
  // ----------------------------------------
  // status conditions
  // ----------------------------------------
  wire rx_warn = ({1'b0, RX_ERR_CNT} >= `CIP_WARN_LIM); // [R5]
  wire tx_warn = (TX_ERR_CNT >= `CIP_WARN_LIM); // [R5]
  wire rx_pass = ({1'b0, RX_ERR_CNT} > `CIP_PASS_LIM); // [R6]
  wire tx_pass = (TX_ERR_CNT > `CIP_PASS_LIM); // [R6]
  wire bus_off = (TX_ERR_CNT > `CIP_BOFF_LIM); // [R6]
  wire wake_evt = sleep_ack & ~RX_PIN & ~power_down;
  wire rx_to_fg = RX_ACCEPT & running & ~rflg_reg[`CIP_RXF_BIT];
  wire rx_to_bg = RX_ACCEPT & running & rflg_reg[`CIP_RXF_BIT] & ~bg_full_reg;
  wire overrun = RX_ACCEPT & running & rflg_reg[`CIP_RXF_BIT] & bg_full_reg; // [R7]
  // pending copy only while the engine runs, never in sleep
  wire copy_go = running & bg_full_reg & ~rflg_reg[`CIP_RXF_BIT] & ~RX_ACCEPT; // [R17] [R20]
  reg [7:0] r_cond;
  reg [7:0] r_set;
  always @* begin
    r_cond = 8'h00;
    r_cond[`CIP_BOFF_BIT] = bus_off;
    r_cond[`CIP_TPAS_BIT] = tx_pass;
    r_cond[`CIP_RPAS_BIT] = rx_pass;
    r_cond[`CIP_TWRN_BIT] = tx_warn;
    r_cond[`CIP_RWRN_BIT] = rx_warn;
    r_set = r_cond;
    r_set[`CIP_RXF_BIT] = rx_to_fg | copy_go; // [R3]
    r_set[`CIP_OVR_BIT] = overrun; // [R7]
    r_set[`CIP_WUP_BIT] = wake_evt & rier_reg[`CIP_WUP_BIT]; // [R4]
  end
  // hardware set wins over a same-cycle clear
  wire [7:0] r_clr = wr_rflg ? (wb & ~r_cond) : 8'h00; // [R9] [R10]
  wire [7:0] rflg_next = (rflg_reg & ~r_clr) | r_set; // [R9]
  wire [2:0] t_clr = wr_tflg ? wb[2:0] : 3'h0; // [R9]
  wire [2:0] tflg_next = (tflg_reg & ~t_clr) | TX_DONE; // [R2]
  // ----------------------------------------
  // mode sequencing
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_SOFT: begin
        if (!soft_rst) begin
          state_next = S_SYNC;
        end
      end
      S_SYNC: begin
        if (soft_rst) begin
          state_next = S_SOFT;
        end else if (BIT_TICK && RX_PIN && rec_cnt_reg == `CIP_RESYNC_BITS - 4'h1) begin
          state_next = S_NORM; // [R20]
        end
      end
      S_NORM: begin
        if (soft_rst) begin
          state_next = S_SOFT; // [R21]
        end else if (slp_req && !TX_BUSY && !RX_BUSY) begin
          state_next = S_SLEEP; // [R15]
        end
      end
      S_SLEEP: begin
        if (soft_rst || !slp_req || wake_evt) begin
          state_next = soft_rst ? S_SOFT : S_SYNC; // [R18]
        end
      end
      default: begin
        state_next = S_SOFT;
      end
    endcase
    if (power_down) begin
      state_next = state_reg; // [R22]
    end
  end
  // ----------------------------------------
  // sequential core
  // ----------------------------------------
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= S_SOFT;
      rec_cnt_reg <= 4'h0;
      mcr0_reg <= `CIP_MCR0_RST;
      mcr1_reg <= 8'h00;
      actl_reg <= 8'h00;
      rflg_reg <= 8'h00;
      rier_reg <= 8'h00;
      tflg_reg <= `CIP_TFLG_RST;
      tier_reg <= 3'h0;
      bg_full_reg <= 1'b0;
      BTR0_OUT <= 8'h00;
      BTR1_OUT <= 8'h00;
      IRQ_TX <= 1'b0;
      IRQ_RX <= 1'b0;
      IRQ_WAKE <= 1'b0;
      IRQ_ERR <= 1'b0;
      CORE_RUN <= 1'b0;
      BUS_ONLINE <= 1'b0;
      TX_RECESSIVE <= 1'b1;
      COPY_STROBE <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg != S_SYNC || (BIT_TICK && !RX_PIN) || state_next != S_SYNC) begin
        rec_cnt_reg <= 4'h0; // [R20]
      end else if (BIT_TICK) begin
        rec_cnt_reg <= rec_cnt_reg + 4'h1;
      end
      if (wr_mcr0) begin
        mcr0_reg[`CIP_SRST_BIT] <= wb[`CIP_SRST_BIT]; // [R21]
        mcr0_reg[`CIP_SIW_BIT] <= wb[`CIP_SIW_BIT];
        if (wb[`CIP_SLRQ_BIT] || sleep_ack) begin
          mcr0_reg[`CIP_SLRQ_BIT] <= wb[`CIP_SLRQ_BIT]; // [R19]
        end
      end else if (wake_evt) begin
        mcr0_reg[`CIP_SLRQ_BIT] <= 1'b0; // [R18]
      end
      if (wr_lock && awaddr_reg == `CIP_MCR1) begin
        mcr1_reg <= wb; // [R13]
      end
      if (wr_lock && awaddr_reg == `CIP_BTR0) begin
        BTR0_OUT <= wb; // [R13]
      end
      if (wr_lock && awaddr_reg == `CIP_BTR1) begin
        BTR1_OUT <= wb; // [R13]
      end
      if (wr_lock && awaddr_reg == `CIP_ACTL) begin
        actl_reg <= wb; // [R13]
      end
      if (wr_ok && awaddr_reg == `CIP_RIER) begin
        rier_reg <= wb; // [R1]
      end
      if (wr_ok && awaddr_reg == `CIP_TIER) begin
        tier_reg <= wb[2:0]; // [R1]
      end
      rflg_reg <= rflg_next;
      tflg_reg <= tflg_next;
      if (rx_to_bg) begin
        bg_full_reg <= 1'b1;
      end else if (copy_go) begin
        bg_full_reg <= 1'b0;
      end
      COPY_STROBE <= copy_go;
      IRQ_TX <= |(tflg_reg & tier_reg); // [R2] [R8] [R23]
      IRQ_RX <= rflg_reg[`CIP_RXF_BIT] & rier_reg[`CIP_RXF_BIT]; // [R3] [R8] [R23]
      IRQ_WAKE <= rflg_reg[`CIP_WUP_BIT] & rier_reg[`CIP_WUP_BIT]; // [R4] [R8] [R23]
      IRQ_ERR <= |(rflg_reg[6:1] & rier_reg[6:1]); // [R5] [R6] [R7] [R8] [R23]
      CORE_RUN <= ~power_down & ((state_next == S_NORM) | (state_next == S_SYNC)); // [R16]
      BUS_ONLINE <= ~power_down & (state_next == S_NORM); // [R20] [R21]
      TX_RECESSIVE <= power_down | (state_next != S_NORM); // [R16] [R22]
    end
  end
  // ----------------------------------------
  // acceptance code and mask storage
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_acc
      always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          acc_mem[gi] <= 8'h00;
        end else if (wr_acc && awaddr_reg[5:2] == gi) begin
          acc_mem[gi] <= wb; // [R13]
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // axi4-lite write channels
  // ----------------------------------------
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= 2'b00;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_got_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
        WREADY <= 1'b0;
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP <= power_down ? 2'b10 : 2'b00; // [R22]
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    case (ARADDR)
      `CIP_MCR0: rd_val[7:0] = {mcr0_reg[7:3], sleep_ack, mcr0_reg[1:0]};
      `CIP_MCR1: rd_val[7:0] = mcr1_reg;
      `CIP_BTR0: rd_val[7:0] = BTR0_OUT;
      `CIP_BTR1: rd_val[7:0] = BTR1_OUT;
      `CIP_ACTL: rd_val[7:0] = actl_reg;
      `CIP_RFLG: rd_val[7:0] = rflg_reg;
      `CIP_RIER: rd_val[7:0] = rier_reg;
      `CIP_TFLG: rd_val[2:0] = tflg_reg;
      `CIP_TIER: rd_val[2:0] = tier_reg;
      `CIP_ECNT: rd_val[16:0] = {TX_ERR_CNT, RX_ERR_CNT}; // [R12]
      `CIP_MODE: rd_val[3:0] = {power_down, bg_full_reg, state_reg};
      default: begin
        if (ARADDR[7:6] == 2'b01 && ARADDR[1:0] == 2'b00) begin
          rd_val[7:0] = acc_mem[ARADDR[5:2]];
        end
      end
    endcase
  end
  wire rd_hit = (ARADDR <= `CIP_MODE && ARADDR[1:0] == 2'b00) ||
    (ARADDR[7:6] == 2'b01 && ARADDR[1:0] == 2'b00);
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= 2'b00;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= power_down ? 32'h0000_0000 : rd_val; // [R22]
      RRESP <= (power_down || !rd_hit) ? 2'b10 : 2'b00;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- verification/cip_can_ctrl_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module cip_props (
  input wire logic CLK,          // clock
  input wire logic RSTN,         // reset, low
  input wire logic AWVALID,      // axi
  input wire logic AWREADY,      // axi
  input wire logic WVALID,       // axi
  input wire logic WREADY,       // axi
  input wire logic [1:0] BRESP,  // axi
  input wire logic BVALID,       // axi
  input wire logic BREADY,       // axi
  input wire logic ARVALID,      // axi
  input wire logic ARREADY,      // axi
  input wire logic [31:0] RDATA, // axi
  input wire logic [1:0] RRESP,  // axi
  input wire logic RVALID,       // axi
  input wire logic CPU_STOP,     // cpu stop
  input wire logic CPU_WAIT,     // cpu wait
  input wire logic BIT_TICK,     // bit pulse
  input wire logic RX_PIN,       // bus level
  input wire logic CORE_RUN,     // engine enable
  input wire logic BUS_ONLINE,   // on bus
  input wire logic TX_RECESSIVE, // tx forced
  input wire logic COPY_STROBE   // copy pulse
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ------
  // recessive bits seen since last dominant bit
  // ------
  logic [3:0] rec_cnt;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN) rec_cnt <= 4'h0;
    else if (BIT_TICK && !RX_PIN) rec_cnt <= 4'h0;
    else if (BIT_TICK && rec_cnt != 4'hF) rec_cnt <= rec_cnt + 4'h1;
  pd_quiet_a: assert property (CPU_STOP |=> TX_RECESSIVE && !BUS_ONLINE && !CORE_RUN)
    else $error("power-down left engine active");
  pd_read_a: assert property (ARVALID && ARREADY && CPU_STOP
    |=> RVALID && RRESP == 2'h2 && RDATA == 32'h0000_0000)
    else $error("read in power-down not refused");
  pd_write_a: assert property (AWVALID && AWREADY && WVALID && WREADY && CPU_STOP
    |-> ##[1:2] (BVALID && BRESP == 2'h2))
    else $error("write in power-down not refused");
  tx_pin_a: assert property (TX_RECESSIVE != BUS_ONLINE)
    else $error("tx pin not recessive off bus");
  online_run_a: assert property (BUS_ONLINE |-> CORE_RUN)
    else $error("online without engine");
  resync_wait_a: assert property ($rose(BUS_ONLINE)
    && !$past(CPU_STOP, 2) && !$past(CPU_WAIT, 2) |-> rec_cnt >= 4'hB)
    else $error("joined bus before eleven recessive bits");
  copy_run_a: assert property (COPY_STROBE |-> CORE_RUN)
    else $error("copy while engine stopped");
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
endmodule
bind cip_can_ctrl cip_props u_props (
  .CLK(CLK), .RSTN(RSTN), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .CPU_STOP(CPU_STOP),
  .CPU_WAIT(CPU_WAIT), .BIT_TICK(BIT_TICK), .RX_PIN(RX_PIN), .CORE_RUN(CORE_RUN),
  .BUS_ONLINE(BUS_ONLINE), .TX_RECESSIVE(TX_RECESSIVE), .COPY_STROBE(COPY_STROBE)
);
`default_nettype wire

// ---- verification/cip_bus_sim.sv ----
`timescale 1ns/1ns
`default_nettype none
module cip_bus_sim #(
  parameter int TICK = 4 // clocks per bit time
) (
  input wire logic CLK,  // clock
  input wire logic RSTN, // reset, low
  input wire logic DOM,  // another node drives dominant
  output logic BIT_TICK, // one pulse per bit
  output logic RX_PIN    // bus level, 1 recessive
);
  int cnt;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt <= 0;
      BIT_TICK <= 1'h0;
    end else begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      BIT_TICK <= (cnt == TICK - 1);
    end
  end
  // bus is pulled recessive whenever no node drives it
  assign RX_PIN = !DOM;
endmodule
`default_nettype wire

// ---- verification/cip_can_ctrl_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module cip_can_ctrl_tb;
  logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic cpu_stop = 0, cpu_wait = 0, rx_acc = 0, tx_busy = 0, rx_busy = 0, dom = 0;
  logic slow_b = 0;
  logic [7:0] awaddr = '0, araddr = '0, rx_err = '0;
  logic [8:0] tx_err = '0;
  logic [2:0] tx_done = '0;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, bit_tick, rx_pin;
  logic irq_tx, irq_rx, irq_wake, irq_err, core_run, online, tx_rec, copy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] btr0, btr1;
  int fail_count = 0, check_count = 0, copies = 0;
  localparam logic [25:0] ROWS [11] = '{
    {8'h04, 8'hA5, 8'hA5, 2'h0}, {8'h08, 8'h5A, 8'h5A, 2'h0}, {8'h0C, 8'h3C, 8'h3C, 2'h0},
    {8'h10, 8'h21, 8'h21, 2'h0}, {8'h40, 8'h11, 8'h11, 2'h0}, {8'h7C, 8'hEE, 8'hEE, 2'h0},
    {8'h18, 8'hFF, 8'hFF, 2'h0}, {8'h20, 8'h07, 8'h07, 2'h0}, {8'h24, 8'hFF, 8'h00, 2'h0},
    {8'h2C, 8'h55, 8'h00, 2'h2}, {8'h28, 8'h03, 8'h00, 2'h0}};
  always #5 clk = ~clk;
  always @(posedge clk) if (copy === 1'h1) copies++;
  cip_bus_sim bus (.CLK(clk), .RSTN(rstn), .DOM(dom), .BIT_TICK(bit_tick), .RX_PIN(rx_pin));
  cip_can_ctrl dut (.CLK(clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CPU_STOP(cpu_stop), .CPU_WAIT(cpu_wait), .RX_ACCEPT(rx_acc), .TX_DONE(tx_done),
    .TX_BUSY(tx_busy), .RX_BUSY(rx_busy), .BIT_TICK(bit_tick), .RX_PIN(rx_pin),
    .RX_ERR_CNT(rx_err), .TX_ERR_CNT(tx_err), .IRQ_TX(irq_tx), .IRQ_RX(irq_rx),
    .IRQ_WAKE(irq_wake), .IRQ_ERR(irq_err), .CORE_RUN(core_run), .BUS_ONLINE(online),
    .TX_RECESSIVE(tx_rec), .COPY_STROBE(copy), .BTR0_OUT(btr0), .BTR1_OUT(btr1));
  task results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task hang;
    fail_count++;
    results;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= !slow_b;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        chk(bresp, r);
        bready <= 1'h0;
        break;
      end
      if (bvalid) bready <= 1'h1;
    end
    if (n == 50) hang;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        chk(rdata, e);
        chk(rresp, r);
        rready <= 1'h0;
        break;
      end
    end
    if (n == 50) hang;
  endtask
  task rb(input logic [7:0] a, input logic [7:0] e);
    rd(a, {24'h00_0000, e}, 2'h0);
  endtask
  task pl(input logic [3:0] v);
    @(posedge clk);
    {rx_acc, tx_done} <= v;
    @(posedge clk);
    {rx_acc, tx_done} <= 4'h0;
    cyc(2);
  endtask
  task wait_online(input logic v);
    int n;
    for (n = 0; n < 300 && online !== v; n++) @(posedge clk);
    if (n == 300) hang;
  endtask
  initial begin
    #500000;
    hang;
  end
  initial begin
    cyc(10);
    rstn <= 1'h1;
    rb(8'h00, 8'h01);
    rb(8'h1C, 8'h07);
    foreach (ROWS[i]) begin
      wr(ROWS[i][25:18], ROWS[i][17:10], 2'h0);
      rd(ROWS[i][25:18], {24'h00_0000, ROWS[i][9:2]}, ROWS[i][1:0]);
    end
    wr(8'h00, 8'h00, 2'h0);
    rb(8'h28, 8'h01);
    wait_online(1'h1);
    wr(8'h08, 8'h11, 2'h0);
    rb(8'h08, 8'h5A);
    chk(btr0, 8'h5A);
    chk(btr1, 8'h3C);
    chk(irq_tx, 1'h1);
    wr(8'h1C, 8'h03, 2'h0);
    rb(8'h1C, 8'h04);
    chk(irq_tx, 1'h1);
    wr(8'h20, 8'h03, 2'h0);
    cyc(1);
    chk(irq_tx, 1'h0);
    wr(8'h20, 8'h07, 2'h0);
    wr(8'h1C, 8'h04, 2'h0);
    cyc(1);
    chk(irq_tx, 1'h0);
    pl(4'h2);
    rb(8'h1C, 8'h02);
    chk(irq_tx, 1'h1);
    wr(8'h1C, 8'h00, 2'h0);
    rb(8'h1C, 8'h02);
    pl(4'h8);
    rb(8'h14, 8'h01);
    chk(irq_rx, 1'h1);
    pl(4'h8);
    pl(4'h8);
    rb(8'h14, 8'h03);
    rb(8'h28, 8'h06);
    chk(irq_err, 1'h1);
    wr(8'h14, 8'h01, 2'h0);
    rb(8'h14, 8'h03);
    chk(copies, 1);
    wr(8'h14, 8'h03, 2'h0);
    rb(8'h14, 8'h00);
    chk({irq_rx, irq_err}, 2'h0);
    rx_err <= 8'h80;
    tx_err <= 9'h100;
    cyc(3);
    rb(8'h14, 8'h7C);
    wr(8'h14, 8'h7C, 2'h0);
    rb(8'h14, 8'h7C);
    wr(8'h24, 8'hFF, 2'h0);
    rd(8'h24, 32'h0001_0080, 2'h0);
    rx_err <= 8'h5F;
    tx_err <= 9'h0FF;
    wr(8'h14, 8'h7C, 2'h0);
    rb(8'h14, 8'h28);
    rx_err <= 8'h60;
    cyc(3);
    rb(8'h14, 8'h68);
    rx_err <= 8'h00;
    tx_err <= 9'h000;
    wr(8'h14, 8'h68, 2'h0);
    cyc(1);
    chk(irq_err, 1'h0);
    tx_busy <= 1'h1;
    rx_busy <= 1'h1;
    wr(8'h00, 8'h02, 2'h0);
    wr(8'h00, 8'h00, 2'h0);
    rb(8'h00, 8'h02);
    tx_busy <= 1'h0;
    cyc(3);
    rb(8'h28, 8'h02);
    rx_busy <= 1'h0;
    cyc(3);
    rb(8'h28, 8'h03);
    rb(8'h00, 8'h06);
    chk({tx_rec, core_run}, 2'h2);
    pl(4'h8);
    rb(8'h14, 8'h00);
    dom <= 1'h1;
    cyc(10);
    dom <= 1'h0;
    cyc(2);
    chk(irq_wake, 1'h1);
    rb(8'h28, 8'h01);
    rb(8'h00, 8'h00);
    wait_online(1'h1);
    wr(8'h14, 8'h80, 2'h0);
    cyc(1);
    chk(irq_wake, 1'h0);
    cpu_stop <= 1'h1;
    cyc(2);
    chk(tx_rec, 1'h1);
    rd(8'h00, 32'h0000_0000, 2'h2);
    wr(8'h18, 8'h00, 2'h2);
    cpu_stop <= 1'h0;
    rb(8'h18, 8'hFF);
    wr(8'h00, 8'h20, 2'h0);
    cpu_wait <= 1'h1;
    rd(8'h28, 32'h0000_0000, 2'h2);
    cpu_wait <= 1'h0;
    wr(8'h00, 8'h00, 2'h0);
    cpu_wait <= 1'h1;
    rb(8'h28, 8'h02);
    cpu_wait <= 1'h0;
    wr(8'h00, 8'h01, 2'h0);
    rb(8'h28, 8'h00);
    chk(online, 1'h0);
    slow_b <= 1'h1;
    wr(8'h08, 8'h77, 2'h0);
    chk(btr0, 8'h77);
    rstn <= 1'h0;
    cyc(2);
    chk({online, tx_rec, core_run, irq_tx}, 4'h4);
    rstn <= 1'h1;
    rb(8'h00, 8'h01);
    chk(btr0, 8'h00);
    results;
  end
endmodule
`default_nettype wire
